// file: bench/bsp_codec.sv
`timescale 1ns/1ps
`default_nettype none

module bsp_codec (
	// Receive link towards the ports.
	output logic [2:0] rxClk,
	output logic [2:0] rxFs,
	output logic [2:0] rxData,
	// Transmit clock and sync when the codec is master.
	output logic [2:0] clkDrv,
	output logic [2:0] fsDrv,
	// Resolved transmit wires.
	input wire logic [2:0] txClk,
	input wire logic [2:0] txFs,
	input wire logic [2:0] txData
);
	logic [15:0] got[3][$];

	initial begin
		{rxClk, rxFs, rxData, clkDrv, fsDrv} = 15'h0000;
	end

	// Sample mid-bit on the falling edge, as the port launches on the rising one.
	for (genvar i = 0; i < 3; i++) begin : g_cap
		int          n = -1;
		logic [15:0] acc;
		always @(negedge txClk[i]) begin
			if (n >= 0) begin
				acc = {acc[14:0], txData[i]};
				n++;
			end else if (txFs[i] === 1'b1) begin
				n = 0;
			end
			if (n == 16) begin
				got[i].push_back(acc);
				n = -1;
			end
		end
	end

	task automatic tick(input int p);
		#6 rxClk[p] = 1'b1;
		#6 rxClk[p] = 1'b0;
	endtask

	// The clock stands still between frames; the data line shows the inverse afterwards.
	task automatic send(input int p, input logic [15:0] w);
		rxFs[p] = 1'b1;
		tick(p);
		rxFs[p] = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			rxData[p] = w[i];
			tick(p);
		end
		rxData[p] = ~rxData[p];
	endtask

	task automatic frame(input int p);
		for (int k = 0; k < 18; k++) begin
			fsDrv[p] = (k == 0);
			#100 clkDrv[p] = 1'b1;
			#400 clkDrv[p] = 1'b0;
			#300;
		end
	endtask
endmodule

`default_nettype wire

// file: bench/bsp_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none

module bsp_top_asserts #(
	parameter int NPORT = 3
) (
	// Clock, reset and float.
	input wire logic             clk,
	input wire logic             rst,
	input wire logic             outFloatN,
	// Directions.
	input wire logic [NPORT-1:0] txClkDirOut,
	input wire logic [NPORT-1:0] txFsDirOut,
	// Transmit pins.
	input wire logic [NPORT-1:0] txShiftClkOe,
	input wire logic [NPORT-1:0] txFrameSyncOut,
	input wire logic [NPORT-1:0] txFrameSyncOe,
	input wire logic [NPORT-1:0] txSerialDataOe
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);

	// The float control crosses a synchroniser, so allow it a few cycles.
	sequence floatHeld;
		!outFloatN [*5];
	endsequence
	sequence wordStart;
		$rose(txSerialDataOe[0]) && txFsDirOut[0];
	endsequence

	outs_idle_a: assert property (
		$fell(rst) |-> !(|(txShiftClkOe | txFrameSyncOe | txSerialDataOe)))
		else $error("pin driven at reset release");
	clk_float_a: assert property (floatHeld |-> !(|txShiftClkOe))
		else $error("shift clock driven in float");
	sync_float_a: assert property (floatHeld |-> !(|txFrameSyncOe))
		else $error("frame sync driven in float");
	data_float_a: assert property (floatHeld |-> !(|txSerialDataOe))
		else $error("data driven in float");
	clk_dir_a: assert property ((!txClkDirOut[0]) [*4] |-> !txShiftClkOe[0])
		else $error("input shift clock driven");
	sync_dir_a: assert property ((!txFsDirOut[0]) [*4] |-> !txFrameSyncOe[0])
		else $error("input frame sync driven");
	sync_leads_a: assert property (wordStart |-> $past(txFrameSyncOut[0]))
		else $error("word without frame sync");
	word_span_a: assert property (
		$rose(txSerialDataOe[0]) |-> txSerialDataOe[0] [*8])
		else $error("data released inside word");
	sync_drive_a: assert property (
		$rose(txFrameSyncOut[0]) && txFsDirOut[0] |-> txFrameSyncOe[0])
		else $error("output frame sync not driven");
endmodule

bind bsp_top bsp_top_asserts #(.NPORT(NPORT)) chk (
	.clk(clk), .rst(rst), .outFloatN(outFloatN), .txClkDirOut(txClkDirOut),
	.txFsDirOut(txFsDirOut), .txShiftClkOe(txShiftClkOe), .txFrameSyncOut(txFrameSyncOut),
	.txFrameSyncOe(txFrameSyncOe), .txSerialDataOe(txSerialDataOe));

`default_nettype wire

// file: bench/buffered_serial_port_pins_test.sv
`timescale 1ns/1ps
`default_nettype none

module buffered_serial_port_pins_test;
	import bsp_pkg::*;
	logic             clk = 1'b0;
	logic             rst = 1'b1;
	logic             outFloatN = 1'b1;
	logic             extOn = 1'b0;
	logic       [2:0] clkDir = 3'h0;
	logic       [2:0] fsDir = 3'h0;
	logic       [2:0] srcExt = 3'h0;
	logic       [2:0] ext = 3'h0;
	logic       [2:0] rxReady = 3'h0;
	logic       [2:0] txValid = 3'h0;
	logic       [2:0] ovrSeen = 3'h0;
	logic       [2:0] undSeen = 3'h0;
	bsp_div_t   [2:0] div = {3{8'h01}};
	bsp_word_t  [2:0] txWord = {3{16'h0000}};
	logic      [31:0] lfsr = 32'h0000A86E;
	logic      [15:0] expRx[3][$];
	logic      [15:0] expTx[3][$];
	int               mismatches = 0;
	int               totalChecks = 0;
	wire        [2:0] rxClk, rxFs, rxD, cDrv, fDrv, tcO, tcOe, tfO, tfOe, tdO, tdOe;
	wire        [2:0] txReady, rxValid, ovr, und, tcW, tfW, tdW;
	wire bsp_word_t [2:0] rxWord;

	assign tcW = (tcOe & tcO) | (~tcOe & cDrv);
	assign tfW = (tfOe & tfO) | (~tfOe & fDrv);
	// A floating data line must not look like a held bit, so it shows the inverse.
	assign tdW = tdO ~^ tdOe;

	always #25 clk = ~clk;
	always #250 if (extOn) ext = ~ext;
	always @(posedge clk) begin
		ovrSeen <= ovrSeen | ovr;
		undSeen <= undSeen | und;
	end

	bsp_top dut (
		.clk(clk), .rst(rst), .outFloatN(outFloatN), .txClkDirOut(clkDir),
		.txFsDirOut(fsDir), .clkSrcExt(srcExt), .clkDiv(div), .rxShiftClk(rxClk),
		.rxFrameSync(rxFs), .rxSerialData(rxD), .txShiftClkIn(tcW), .txShiftClkOut(tcO),
		.txShiftClkOe(tcOe), .txFrameSyncIn(tfW), .txFrameSyncOut(tfO),
		.txFrameSyncOe(tfOe), .txSerialDataOut(tdO), .txSerialDataOe(tdOe),
		.extClockReference(ext), .rxWord(rxWord), .rxValid(rxValid), .rxReady(rxReady),
		.rxOverrun(ovr), .txWord(txWord), .txValid(txValid), .txReady(txReady),
		.txUnderrun(und));

	bsp_codec cod (
		.rxClk(rxClk), .rxFs(rxFs), .rxData(rxD), .clkDrv(cDrv), .fsDrv(fDrv),
		.txClk(tcW), .txFs(tfW), .txData(tdW));

	function automatic logic [15:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr[15:0];
	endfunction

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		totalChecks++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic put(input int p, input logic [15:0] w);
		@(negedge clk);
		txWord[p] = w;
		txValid[p] = 1'b1;
		while (txReady[p] !== 1'b1) @(negedge clk);
		@(negedge clk);
		txValid[p] = 1'b0;
		expTx[p].push_back(w);
	endtask

	task automatic drain(input int p);
		repeat (40) begin
			@(negedge clk);
			rxReady[p] = rxValid[p];
			if (rxValid[p] === 1'b1) check(rxWord[p], expRx[p].pop_front());
		end
		rxReady[p] = 1'b0;
		check(16'(expRx[p].size()), 16'h0000);
	endtask

	task automatic sendTx(input int p);
		for (int i = 0; i < 3000 && cod.got[p].size() < expTx[p].size(); i++) @(negedge clk);
		while (expTx[p].size() > 0) check(cod.got[p].pop_front(), expTx[p].pop_front());
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", totalChecks, mismatches);
		if (mismatches == 0 && totalChecks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	initial begin
		#1000000;
		mismatches++;
		print_verdict();
	end

	initial begin
		repeat (2) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		for (int p = 0; p < 3; p++) begin
			ovrSeen = 3'h0;
			// The reader stalls, so the third word meets a full buffer and is lost.
			for (int k = 0; k < 3; k++) begin
				txWord[p] = rnd();
				if (k < 2) expRx[p].push_back(txWord[p]);
				cod.send(p, txWord[p]);
				#400;
			end
			drain(p);
			check(16'(ovrSeen), 16'(1 << p));
		end
		$display("receive test done");
		clkDir = 3'h7;
		fsDir = 3'h7;
		for (int p = 0; p < 3; p++) begin
			repeat (4) put(p, rnd());
			sendTx(p);
		end
		outFloatN = 1'b0;
		repeat (6) @(negedge clk);
		check(16'(tcOe | tfOe | tdOe), 16'h0000);
		outFloatN = 1'b1;
		repeat (6) @(negedge clk);
		check(16'(tcOe & tfOe), 16'h0007);
		check(16'(tdOe), 16'h0000);
		$display("transmit output test done");
		srcExt = 3'h7;
		for (int p = 0; p < 3; p++) begin
			put(p, rnd());
			repeat (100) @(negedge clk);
			check(16'(cod.got[p].size()), 16'h0000);
			extOn = 1'b1;
			sendTx(p);
			extOn = 1'b0;
		end
		srcExt = 3'h0;
		$display("clock source test done");
		clkDir = 3'h0;
		fsDir = 3'h0;
		for (int p = 0; p < 3; p++) begin
			undSeen = 3'h0;
			cod.frame(p);
			check(16'(undSeen), 16'(1 << p));
			// The empty frame clocked the floating line into the codec, which is no word.
			cod.got[p].delete();
			put(p, rnd());
			cod.frame(p);
			sendTx(p);
		end
		$display("transmit input test done");
		clkDir = 3'h7;
		fsDir = 3'h7;
		repeat (4) @(negedge clk);
		rst = 1'b1;
		@(negedge clk);
		check(16'(tcOe | tfOe | tdOe), 16'h0000);
		rst = 1'b0;
		$display("reset test done");
		print_verdict();
	end
endmodule

`default_nettype wire

// file: hw/bsp_cfg.svh
`ifndef BSP_CFG_SVH
`define BSP_CFG_SVH

// Port count and word geometry.
`define BSP_NPORT      3
`define BSP_WORD_W     16
`define BSP_CNT_W      5
`define BSP_WORD_BITS  5'h10
`define BSP_LAST_BIT   5'h0F
`define BSP_CNT_ZERO   5'h00
`define BSP_CNT_ONE    5'h01

// Clock divider for the generated transmit shift clock.
`define BSP_DIV_W      8
`define BSP_DIV_ZERO   8'h00
`define BSP_DIV_ONE    8'h01

// Lanes of the per-port synchroniser.
`define BSP_SYNC_W     4
`define BSP_SY_TXCLK   0
`define BSP_SY_TXFS    1
`define BSP_SY_EXT     2
`define BSP_SY_TOG     3

// Two-entry buffer occupancy.
`define BSP_SKID_EMPTY 2'h0
`define BSP_SKID_ONE   2'h1
`define BSP_SKID_FULL  2'h2

`endif

// file: hw/bsp_pkg.sv
`include "bsp_cfg.svh"

package bsp_pkg;

	typedef enum logic [1:0] {
		BSP_TX_IDLE  = 2'h0,
		BSP_TX_FSYNC = 2'h1,
		BSP_TX_SHIFT = 2'h3
	} bsp_tx_state_t;

	typedef logic [`BSP_WORD_W-1:0] bsp_word_t;
	typedef logic [`BSP_CNT_W-1:0]  bsp_cnt_t;
	typedef logic [`BSP_DIV_W-1:0]  bsp_div_t;

	// Transmitter and receive hand-off state, system clock domain.
	typedef struct packed {
		bsp_tx_state_t state;
		logic          cfgClkOut;
		logic          cfgFsOut;
		logic          cfgExt;
		bsp_div_t      div;
		bsp_div_t      divCnt;
		logic          genClk;
		logic          extPrev;
		logic          bitPrev;
		bsp_word_t     shift;
		bsp_cnt_t      cnt;
		logic          txd;
		logic          fs;
		logic          act;
		logic          clkOe;
		logic          fsOe;
		logic          dOe;
		logic          underrun;
		logic          togPrev;
		logic          overrun;
	} bsp_tx_t;

	// Receiver state, receive shift clock domain.
	typedef struct packed {
		logic      busy;
		bsp_cnt_t  cnt;
		bsp_word_t shift;
		bsp_word_t hold;
		logic      tog;
	} bsp_rx_t;

endpackage

// file: hw/bsp_skid.sv
`timescale 1ns/1ps
`default_nettype none
`include "bsp_cfg.svh"

module bsp_skid #(
	parameter int W = 16
) (
	// Clock and reset.
	input  wire logic         clk,
	input  wire logic         rst,
	// Filling side.
	input  wire logic         inValid,
	output logic              inReady,
	input  wire logic [W-1:0] inData,
	// Draining side.
	output logic              outValid,
	input  wire logic         outReady,
	output logic      [W-1:0] outData
);
	typedef struct packed {
		logic [1:0][W-1:0] mem;
		logic              wp;
		logic              rp;
		logic [1:0]        cnt;
	} bsp_skid_state_t;

	bsp_skid_state_t r_reg;
	bsp_skid_state_t r_next;
	logic            push;
	logic            pop;

	assign inReady  = (r_reg.cnt != `BSP_SKID_FULL);
	assign outValid = (r_reg.cnt != `BSP_SKID_EMPTY);
	assign outData  = r_reg.mem[r_reg.rp];
	assign push     = inValid & inReady;
	assign pop      = outValid & outReady;

	always_comb begin
		r_next = r_reg;
		if (push) begin
			r_next.mem[r_reg.wp] = inData;
			r_next.wp            = ~r_reg.wp;
		end
		if (pop) begin
			r_next.rp = ~r_reg.rp;
		end
		if (push && !pop) begin
			r_next.cnt = (r_reg.cnt == `BSP_SKID_EMPTY) ? `BSP_SKID_ONE : `BSP_SKID_FULL;
		end else if (pop && !push) begin
			r_next.cnt = (r_reg.cnt == `BSP_SKID_FULL) ? `BSP_SKID_ONE : `BSP_SKID_EMPTY;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end
endmodule

`default_nettype wire

// file: hw/bsp_sync.sv
`timescale 1ns/1ps
`default_nettype none

module bsp_sync #(
	parameter int W = 1
) (
	// Clock and reset.
	input  wire logic         clk,
	input  wire logic         rst,
	// Levels in and out.
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} bsp_sync_state_t;

	bsp_sync_state_t r_reg;
	bsp_sync_state_t r_next;

	// Only the second stage is visible; the first may be metastable.
	always_comb begin
		r_next    = r_reg;
		r_next.s1 = d;
		r_next.s2 = r_reg.s1;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign q = r_reg.s2;
endmodule

`default_nettype wire

// file: hw/bsp_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "bsp_cfg.svh"

// Operation
// - A receive frame sync pulse starts each receive word on the data pin.
// - Transmit data shifts out on the transmit shift clock.
// - Transmit shift clock direction is programmable; input after reset.
// - Transmit shift clock floats while the output-float control is low.
// - Transmit data is driven only while shifting a word, never in reset or float.
// - A transmit frame sync pulse starts each transmit word on the data pin.
// - Transmit frame sync direction is programmable; input after reset.
// - Transmit frame sync floats while the output-float control is low.
// - Internal clock generation uses the external reference or system clock; internal frame sync is timed by the shift clock in use.
// - Receive data is sampled on the receive shift clock.
module bsp_top #(
	parameter int NPORT = `BSP_NPORT
) (
	// System clock, reset and global output float.
	input  wire logic                                clk,
	input  wire logic                                rst,
	input  wire logic                                outFloatN,
	// Per-port configuration from the processor side.
	input  wire logic     [NPORT-1:0]                txClkDirOut,
	input  wire logic     [NPORT-1:0]                txFsDirOut,
	input  wire logic     [NPORT-1:0]                clkSrcExt,
	input  wire bsp_pkg::bsp_div_t [NPORT-1:0]       clkDiv,
	// Receive pins.
	input  wire logic     [NPORT-1:0]                rxShiftClk,
	input  wire logic     [NPORT-1:0]                rxFrameSync,
	input  wire logic     [NPORT-1:0]                rxSerialData,
	// Transmit pins.
	input  wire logic     [NPORT-1:0]                txShiftClkIn,
	output logic          [NPORT-1:0]                txShiftClkOut,
	output logic          [NPORT-1:0]                txShiftClkOe,
	input  wire logic     [NPORT-1:0]                txFrameSyncIn,
	output logic          [NPORT-1:0]                txFrameSyncOut,
	output logic          [NPORT-1:0]                txFrameSyncOe,
	output logic          [NPORT-1:0]                txSerialDataOut,
	output logic          [NPORT-1:0]                txSerialDataOe,
	input  wire logic     [NPORT-1:0]                extClockReference,
	// Received words towards the processor.
	output bsp_pkg::bsp_word_t [NPORT-1:0]           rxWord,
	output logic          [NPORT-1:0]                rxValid,
	input  wire logic     [NPORT-1:0]                rxReady,
	output logic          [NPORT-1:0]                rxOverrun,
	// Words to transmit from the processor.
	input  wire bsp_pkg::bsp_word_t [NPORT-1:0]      txWord,
	input  wire logic     [NPORT-1:0]                txValid,
	output logic          [NPORT-1:0]                txReady,
	output logic          [NPORT-1:0]                txUnderrun
);
	import bsp_pkg::*;

	function automatic bsp_cnt_t cntInc(input bsp_cnt_t c);
		cntInc = c + `BSP_CNT_ONE;
	endfunction

	// One serial step: the word moves up a place and the new bit enters at the bottom.
	function automatic bsp_word_t shiftIn(input bsp_word_t s, input logic b);
		shiftIn = {s[`BSP_WORD_W-2:0], b};
	endfunction

	function automatic logic wordMsb(input bsp_word_t s);
		wordMsb = s[`BSP_WORD_W-1];
	endfunction

	logic offSync;

	// The float control is a pin, so it is synchronised like the transmit clock, frame sync and reference inputs.
	bsp_sync #(
		.W(1)
	) u_off_sync (
		.clk(clk),
		.rst(rst),
		.d  (outFloatN),
		.q  (offSync)
	);

	genvar i;
	generate
		for (i = 0; i < NPORT; i = i + 1) begin : g_port
			bsp_tx_t                r_reg;
			bsp_tx_t                r_next;
			bsp_rx_t                q_reg;
			bsp_rx_t                q_next;
			logic [`BSP_SYNC_W-1:0] sy;
			bsp_word_t              bufData;
			logic                   bufValid;
			logic                   bufPop;
			logic                   rxPush;
			logic                   rxInReady;
			logic                   extRise;
			logic                   srcTick;
			logic                   bitLvl;
			logic                   bitRise;

			// The receive toggle crosses as a level; the word itself is held
			// stable in the link domain long enough to be read after it.
			bsp_sync #(
				.W(`BSP_SYNC_W)
			) u_sync (
				.clk(clk),
				.rst(rst),
				.d  ({q_reg.tog, extClockReference[i], txFrameSyncIn[i], txShiftClkIn[i]}),
				.q  (sy)
			);

			bsp_skid #(
				.W(`BSP_WORD_W)
			) u_tx_buf (
				.clk     (clk),
				.rst     (rst),
				.inValid (txValid[i]),
				.inReady (txReady[i]),
				.inData  (txWord[i]),
				.outValid(bufValid),
				.outReady(bufPop),
				.outData (bufData)
			);

			bsp_skid #(
				.W(`BSP_WORD_W)
			) u_rx_buf (
				.clk     (clk),
				.rst     (rst),
				.inValid (rxPush),
				.inReady (rxInReady),
				.inData  (q_reg.hold),
				.outValid(rxValid[i]),
				.outReady(rxReady[i]),
				.outData (rxWord[i])
			);

			// Receiver, clocked by the receive shift clock itself.
			always_comb begin
				q_next = q_reg;
				if (!q_reg.busy) begin
					if (rxFrameSync[i]) begin
						q_next.busy = 1'b1;
						q_next.cnt  = `BSP_CNT_ZERO;
					end
				end else begin
					q_next.shift = shiftIn(q_reg.shift, rxSerialData[i]);
					q_next.cnt   = cntInc(q_reg.cnt);
					if (q_reg.cnt == `BSP_LAST_BIT) begin
						q_next.hold = shiftIn(q_reg.shift, rxSerialData[i]);
						q_next.tog  = ~q_reg.tog;
						q_next.busy = 1'b0;
					end
				end
			end

			always_ff @(posedge rxShiftClk[i] or posedge rst) begin
				if (rst) begin
					q_reg <= '0;
				end else begin
					q_reg <= q_next;
				end
			end

			assign rxPush  = sy[`BSP_SY_TOG] ^ r_reg.togPrev;
			assign extRise = sy[`BSP_SY_EXT] & ~r_reg.extPrev;
			assign srcTick = r_reg.cfgExt ? extRise : 1'b1;
			assign bitLvl  = r_reg.cfgClkOut ? r_reg.genClk : sy[`BSP_SY_TXCLK];
			assign bitRise = bitLvl & ~r_reg.bitPrev;
			assign bufPop  = bitRise & bufValid & (r_reg.state == BSP_TX_IDLE) &
				(r_reg.cfgFsOut | sy[`BSP_SY_TXFS]);

			// Transmitter and receive hand-off, system clock domain.
			always_comb begin
				r_next           = r_reg;
				r_next.underrun  = 1'b0;
				r_next.overrun   = 1'b0;
				// Configuration registers reset to zero, so both pins start as inputs.
				r_next.cfgClkOut = txClkDirOut[i];
				r_next.cfgFsOut  = txFsDirOut[i];
				r_next.cfgExt    = clkSrcExt[i];
				r_next.div       = clkDiv[i];
				r_next.extPrev   = sy[`BSP_SY_EXT];
				r_next.bitPrev   = bitLvl;
				r_next.togPrev   = sy[`BSP_SY_TOG];
				if (rxPush && !rxInReady) begin
					r_next.overrun = 1'b1;
				end
				if (srcTick) begin
					if (r_reg.divCnt == r_reg.div) begin
						r_next.divCnt = `BSP_DIV_ZERO;
						r_next.genClk = ~r_reg.genClk;
					end else begin
						r_next.divCnt = r_reg.divCnt + `BSP_DIV_ONE;
					end
				end
				if (bitRise) begin
					unique case (r_reg.state)
						BSP_TX_IDLE: begin
							if (r_reg.cfgFsOut) begin
								if (bufValid) begin
									r_next.shift = bufData;
									r_next.fs    = 1'b1;
									r_next.state = BSP_TX_FSYNC;
								end
							end else if (sy[`BSP_SY_TXFS]) begin
								if (bufValid) begin
									r_next.shift = bufData;
									r_next.cnt   = `BSP_CNT_ZERO;
									r_next.state = BSP_TX_SHIFT;
								end else begin
									r_next.underrun = 1'b1;
								end
							end
						end
						BSP_TX_FSYNC: begin
							r_next.fs    = 1'b0;
							r_next.txd   = wordMsb(r_reg.shift);
							r_next.shift = shiftIn(r_reg.shift, 1'b0);
							r_next.cnt   = `BSP_CNT_ONE;
							r_next.act   = 1'b1;
							r_next.state = BSP_TX_SHIFT;
						end
						BSP_TX_SHIFT: begin
							if (r_reg.cnt == `BSP_WORD_BITS) begin
								r_next.act   = 1'b0;
								r_next.state = BSP_TX_IDLE;
							end else begin
								r_next.txd   = wordMsb(r_reg.shift);
								r_next.shift = shiftIn(r_reg.shift, 1'b0);
								r_next.cnt   = cntInc(r_reg.cnt);
								r_next.act   = 1'b1;
							end
						end
					endcase
				end
				// Enables are registered so the pins never glitch on a config change.
				r_next.clkOe = r_next.cfgClkOut & offSync;
				r_next.fsOe  = r_next.cfgFsOut & offSync;
				r_next.dOe   = r_next.act & offSync;
			end

			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					r_reg <= '0;
				end else begin
					r_reg <= r_next;
				end
			end

			assign txShiftClkOut[i]   = r_reg.genClk;
			assign txShiftClkOe[i]    = r_reg.clkOe;
			assign txFrameSyncOut[i]  = r_reg.fs;
			assign txFrameSyncOe[i]   = r_reg.fsOe;
			assign txSerialDataOut[i] = r_reg.txd;
			assign txSerialDataOe[i]  = r_reg.dOe;
			assign rxOverrun[i]       = r_reg.overrun;
			assign txUnderrun[i]      = r_reg.underrun;
		end
	endgenerate
endmodule

`default_nettype wire
